/* hw/bir_regs.sv */
// Bus options and unique identifier registers behind an APB slave
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
// How it works
// - Bus manager capable bit 28 is read/write, resets to zero.
// - Power-management capable bit 27 is read/write, resets to zero.
// - Clock accuracy field bits 23..16 is read/write, resets to 00h.
// - Request size code bits 15..12; bytes are two to code plus one, at least 512.
// - Request size code resets to Bh on hardware reset only, not software reset.
// - Block writes longer than the request byte count may get a type error acknowledge.
// - Reserved bits 26..24, 11..8, 5..3 ignore writes and read zero.
// - Generation bits 7..6 are writable and count up when ROM changed since bus reset.
// - Link speed bits 2..0 are read-only and always return 011b.
// - Identifier high register at 24h holds upper identifier word.
// - Both identifier words clear to zero on hardware reset; zero is invalid.
// - With an EEPROM present the identifier is loaded from the EEPROM interface.
// - After loading, identifier contents are frozen until the next reset.
// - Identifier words also clear on PCIe reset, global reset pin or power-on reset.
// - Identifier low register at 28h holds lower word and behaves like the high one.
module bir_regs
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [bir_pkg::BIR_ADDR_W-1:0] paddr,
  input wire logic [bir_pkg::BIR_DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [bir_pkg::BIR_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sw_reset,
  input wire logic perst_b,
  input wire logic global_reset_pin_b,
  input wire logic por_b,
  input wire logic bus_reset,
  input wire logic rom_changed,
  input wire logic eeprom_present,
  input wire logic ee_load_valid,
  input wire logic [31:0] ee_load_high,
  input wire logic [31:0] ee_load_low,
  input wire logic fw_load_valid,
  input wire logic [31:0] fw_load_high,
  input wire logic [31:0] fw_load_low,
  input wire logic rx_blk_wr_valid,
  input wire logic [bir_pkg::BIR_LEN_W-1:0] rx_blk_wr_len,
  output logic ack_type_error,
  output logic id_locked
);
  import bir_pkg::*;

  // Bus option fields
  logic bmc_q;
  logic bmc_d;
  logic pmc_q;
  logic pmc_d;
  logic [7:0] acc_q;
  logic [7:0] acc_d;
  logic [3:0] mrec_q;
  logic [3:0] mrec_d;
  logic [1:0] gen_q;
  logic [1:0] gen_d;
  logic rom_dirty_q;
  logic rom_dirty_d;
  // Identifier state
  bir_id_state_type id_state_q;
  bir_id_state_type id_state_d;
  logic [31:0] id_word [BIR_ID_WORDS];
  logic [31:0] id_din [BIR_ID_WORDS];
  // APB outputs
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic pready_q;
  logic pready_d;
  logic pslverr_q;
  logic pslverr_d;
  logic ack_err_q;
  logic ack_err_d;

  // Decode
  wire access_ph = psel & penable;
  wire first_acc = access_ph & ~pready_q;
  wire commit = access_ph & pready_q;
  wire sel_opts = (paddr == BIR_OFF_OPTS);
  wire sel_idh = (paddr == BIR_OFF_ID_HIGH);
  wire sel_idl = (paddr == BIR_OFF_ID_LOW);
  wire sel_stat = (paddr == BIR_OFF_ID_STAT);
  wire hit = sel_opts | sel_idh | sel_idl | sel_stat;
  // Identifier words and status are never written by software
  wire wr_opts = commit & pwrite & sel_opts;
  wire wr_b3 = wr_opts & pstrb[3];
  wire wr_b2 = wr_opts & pstrb[2];
  wire wr_b1 = wr_opts & pstrb[1];
  wire wr_b0 = wr_opts & pstrb[0];

  // Read view; reserved bits and bits 31..29 read zero
  wire [31:0] opts_view = {3'b000, bmc_q, pmc_q, 3'b000, acc_q, mrec_q, 4'h0, gen_q, 3'b000,
                           BIR_SPD_VAL};
  wire [31:0] stat_view = {30'h0000_0000, eeprom_present, id_locked};
  wire [31:0] rd_mux = sel_opts ? opts_view :
                       sel_idh ? id_word[0] :
                       sel_idl ? id_word[1] :
                       sel_stat ? stat_view : BIR_ZERO_WORD;

  assign pready_d = first_acc;
  assign pslverr_d = first_acc & ~hit;
  assign prdata_d = (first_acc & ~pwrite) ? rd_mux : prdata_q;

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= BIR_ZERO_WORD;
    end
    else if (ce)
    begin
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  // Capability bits and accuracy, cleared by software reset as well
  assign bmc_d = sw_reset ? BIR_BMC_RST : (wr_b3 ? pwdata[BIR_BMC_BIT] : bmc_q);
  assign pmc_d = sw_reset ? BIR_PMC_RST : (wr_b3 ? pwdata[BIR_PMC_BIT] : pmc_q);
  assign acc_d = sw_reset ? BIR_ACC_RST : (wr_b2 ? pwdata[BIR_ACC_MSB:BIR_ACC_LSB] : acc_q);

  // Codes below 512 bytes are refused so the field never goes illegal
  wire [3:0] mrec_wr = pwdata[BIR_MREC_MSB:BIR_MREC_LSB];
  wire mrec_ok = (mrec_wr >= BIR_MREC_MIN);
  // Software reset does not touch the request size
  assign mrec_d = (wr_b1 & mrec_ok) ? mrec_wr : mrec_q;

  // ROM change remembered until the next bus reset; a change in the bus reset cycle is used up by that bump
  wire rom_pending = rom_dirty_q | rom_changed;
  assign rom_dirty_d = ~bus_reset & rom_pending;
  wire gen_bump = bus_reset & rom_pending;
  // Software write wins over a bump in the same cycle
  assign gen_d = sw_reset ? BIR_GEN_RST :
                 wr_b0 ? pwdata[BIR_GEN_MSB:BIR_GEN_LSB] :
                 gen_bump ? 2'(gen_q + 2'h1) : gen_q;

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      bmc_q <= BIR_BMC_RST;
      pmc_q <= BIR_PMC_RST;
      acc_q <= BIR_ACC_RST;
      mrec_q <= BIR_MREC_RST;
      gen_q <= BIR_GEN_RST;
      rom_dirty_q <= 1'b0;
    end
    else if (ce)
    begin
      bmc_q <= bmc_d;
      pmc_q <= pmc_d;
      acc_q <= acc_d;
      mrec_q <= mrec_d;
      gen_q <= gen_d;
      rom_dirty_q <= rom_dirty_d;
    end
  end

  // Request length check against two to the code plus one
  wire [4:0] shift_amt = 5'({1'b0, mrec_q} + 5'h01);
  wire [BIR_MAXB_W-1:0] max_bytes = BIR_MAXB_W'(17'h0_0001 << shift_amt);
  wire [BIR_MAXB_W-1:0] len_ext = {1'b0, rx_blk_wr_len};
  assign ack_err_d = rx_blk_wr_valid & (len_ext > max_bytes);

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      ack_err_q <= 1'b0;
    else if (ce)
      ack_err_q <= ack_err_d;
  end

  assign ack_type_error = ack_err_q;

  // Identifier reset sources, sampled as synchronous levels
  wire id_clr = ~perst_b | ~global_reset_pin_b | ~por_b;
  // EEPROM has priority; firmware loads count only without one
  wire ld_req = eeprom_present ? ee_load_valid : fw_load_valid;
  wire id_load = (id_state_q == BIR_ID_EMPTY) & ld_req & ~id_clr;

  assign id_din[0] = eeprom_present ? ee_load_high : fw_load_high;
  assign id_din[1] = eeprom_present ? ee_load_low : fw_load_low;

  always_comb
  begin
    case (id_state_q)
      BIR_ID_EMPTY: id_state_d = id_load ? BIR_ID_LOCKED : BIR_ID_EMPTY;
      BIR_ID_LOCKED: id_state_d = id_clr ? BIR_ID_EMPTY : BIR_ID_LOCKED;
      default: id_state_d = BIR_ID_EMPTY;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      id_state_q <= BIR_ID_EMPTY;
    else if (ce)
      id_state_q <= id_state_d;
  end

  // One-hot, so the locked bit is the output flop itself
  assign id_locked = id_state_q[1];

  // Both words share one load and one clear so they lock as a pair
  genvar gi;
  generate
    for (gi = 0; gi < BIR_ID_WORDS; gi++)
    begin : g_id
      bir_id_word u_word
      (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .ce(ce),
        .clr(id_clr),
        .load(id_load),
        .din(id_din[gi]),
        .word_q(id_word[gi])
      );
    end
  endgenerate

  // Checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);

  a_bmc_write_lands: assert property (
    ce && wr_b3 && !sw_reset |=> bmc_q == $past(pwdata[BIR_BMC_BIT]))
    else $error("bus manager bit did not take the written value");

  a_pmc_write_lands: assert property (
    ce && wr_b3 && !sw_reset |=> pmc_q == $past(pwdata[BIR_PMC_BIT]))
    else $error("power management bit did not take the written value");

  a_acc_sw_clear: assert property (
    ce && sw_reset |=> acc_q == BIR_ACC_RST && !bmc_q && !pmc_q)
    else $error("software reset left capability or accuracy set");

  a_mrec_keeps_swrst: assert property (
    ce && sw_reset && !wr_b1 |=> $stable(mrec_q))
    else $error("software reset changed request size");

  a_mrec_floor: assert property (
    mrec_q >= BIR_MREC_MIN)
    else $error("request size code below 512 bytes");

  a_ack_err_len: assert property (
    ce && rx_blk_wr_valid && (len_ext > max_bytes) |=> ack_type_error)
    else $error("oversize block write not flagged");

  a_rsvd_read_zero: assert property (
    pready && !pslverr && $past(sel_opts) && $past(!pwrite) |->
      prdata[26:24] == 3'b000 && prdata[11:8] == 4'h0 && prdata[5:3] == 3'b000 && prdata[2:0] == BIR_SPD_VAL)
    else $error("bus options reserved or speed bits wrong");

  a_gen_bump: assert property (
    ce && gen_bump && !wr_b0 && !sw_reset |=> gen_q == 2'($past(gen_q) + 2'h1))
    else $error("generation counter did not advance");

  a_id_frozen: assert property (
    ce && id_locked && !id_clr |=> $stable(id_word[0]) && $stable(id_word[1]))
    else $error("identifier changed while locked");

  a_id_clear: assert property (
    ce && id_clr |=> id_word[0] == BIR_ID_RST && id_word[1] == BIR_ID_RST && !id_locked)
    else $error("identifier not cleared by reset source");

  a_id_ee_load: assert property (
    ce && id_load && eeprom_present |=> id_word[0] == $past(ee_load_high) && id_word[1] == $past(ee_load_low))
    else $error("identifier not taken from eeprom");

  a_apb_answer: assert property (
    ce && first_acc |=> pready ##1 !pready)
    else $error("apb answer timing broken");

  // Field writes, generation, type error, identifier and APB answer checks
  a_mrec_write_lands: assert property (
    ce && wr_b1 && mrec_ok |=> mrec_q == $past(mrec_wr))
    else $error("request size code did not take the written value");

  a_mrec_low_refused: assert property (
    ce && wr_b1 && !mrec_ok |=> $stable(mrec_q))
    else $error("request size code below 512 bytes was taken");

  a_acc_write_lands: assert property (
    ce && wr_b2 && !sw_reset |=> acc_q == $past(pwdata[BIR_ACC_MSB:BIR_ACC_LSB]))
    else $error("clock accuracy did not take the written value");

  a_gen_write_lands: assert property (
    ce && wr_b0 && !sw_reset |=> gen_q == $past(pwdata[BIR_GEN_MSB:BIR_GEN_LSB]))
    else $error("generation counter did not take the written value");

  a_gen_holds_idle: assert property (
    ce && !bus_reset && !wr_b0 && !sw_reset |=> $stable(gen_q))
    else $error("generation counter moved without cause");

  a_rom_dirty_used: assert property (
    ce && bus_reset |=> !rom_dirty_q)
    else $error("configuration change still pending after bus reset");

  a_gen_sw_clear: assert property (
    ce && sw_reset |=> gen_q == BIR_GEN_RST)
    else $error("software reset left generation counter set");

  a_ack_err_quiet: assert property (
    ce && !rx_blk_wr_valid |=> !ack_type_error)
    else $error("type error without a block write");

  a_id_fw_load: assert property (
    ce && id_load && !eeprom_present |=> id_word[0] == $past(fw_load_high) && id_word[1] == $past(fw_load_low))
    else $error("identifier not taken from firmware load");

  a_id_lock_set: assert property (
    ce && id_load |=> id_locked)
    else $error("identifier load did not lock");

  a_id_sw_ignored: assert property (
    ce && commit && pwrite && (sel_idh || sel_idl) && !id_load && !id_clr |=>
      $stable(id_word[0]) && $stable(id_word[1]))
    else $error("software write changed the identifier");

  a_unmapped_error: assert property (
    ce && first_acc && !hit |=> pready && pslverr)
    else $error("unmapped access not answered with an error");

  a_prdata_holds: assert property (
    ce && !(first_acc && !pwrite) |=> $stable(prdata))
    else $error("read data changed outside a read");
endmodule // bir_regs

/* hw/bir_pkg.sv */
// Package with offsets, field layout and reset values of the bus information registers
package bir_pkg;
  localparam int BIR_ADDR_W = 12;
  localparam int BIR_DATA_W = 32;
  localparam int BIR_LEN_W = 16;
  localparam int BIR_MAXB_W = 17;
  localparam int BIR_ID_WORDS = 2;
  // Register byte offsets
  localparam logic [11:0] BIR_OFF_OPTS = 12'h020;
  localparam logic [11:0] BIR_OFF_ID_HIGH = 12'h024;
  localparam logic [11:0] BIR_OFF_ID_LOW = 12'h028;
  localparam logic [11:0] BIR_OFF_ID_STAT = 12'h02C;
  // Bus options field positions
  localparam int BIR_BMC_BIT = 28;
  localparam int BIR_PMC_BIT = 27;
  localparam int BIR_ACC_LSB = 16;
  localparam int BIR_ACC_MSB = 23;
  localparam int BIR_MREC_LSB = 12;
  localparam int BIR_MREC_MSB = 15;
  localparam int BIR_GEN_LSB = 6;
  localparam int BIR_GEN_MSB = 7;
  localparam int BIR_SPD_LSB = 0;
  localparam int BIR_SPD_MSB = 2;
  // Identifier status field positions
  localparam int BIR_STAT_LOCK_BIT = 0;
  localparam int BIR_STAT_EE_BIT = 1;
  // Reset and fixed values
  localparam logic BIR_BMC_RST = 1'b0;
  localparam logic BIR_PMC_RST = 1'b0;
  localparam logic [7:0] BIR_ACC_RST = 8'h00;
  localparam logic [3:0] BIR_MREC_RST = 4'hB;
  localparam logic [3:0] BIR_MREC_MIN = 4'h8;
  localparam logic [1:0] BIR_GEN_RST = 2'h0;
  localparam logic [2:0] BIR_SPD_VAL = 3'h3;
  localparam logic [31:0] BIR_ID_RST = 32'h0000_0000;
  localparam logic [31:0] BIR_ZERO_WORD = 32'h0000_0000;
  // Identifier load state, one-hot
  typedef enum logic [1:0] {
    BIR_ID_EMPTY = 2'b01,
    BIR_ID_LOCKED = 2'b10
  } bir_id_state_type;
endpackage

/* hw/bir_id_word.sv */
// One identifier word that is cleared by reset and loaded by the load path only
`timescale 1ns/1ps
module bir_id_word
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic clr,
  input wire logic load,
  input wire logic [31:0] din,
  output logic [31:0] word_q
);
  import bir_pkg::*;

  logic [31:0] word_d;

  // Clear wins: a reset event must leave the invalid all-zero value
  assign word_d = clr ? BIR_ID_RST : (load ? din : word_q);

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      word_q <= BIR_ID_RST;
    else if (ce)
      word_q <= word_d;
  end
endmodule // bir_id_word

/* sim/bir_ee_model.sv */
// Serial EEPROM model that hands over the stored identifier after a delay
`timescale 1ns/1ps
module bir_ee_model
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic go,
  input wire logic [31:0] word_high,
  input wire logic [31:0] word_low,
  output logic ee_load_valid,
  output logic [31:0] ee_load_high,
  output logic [31:0] ee_load_low
);
  logic busy_q;
  logic [3:0] wait_q;
  // Delay comes from the data, so prompt and slow loads both occur
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      busy_q <= 1'b0;
      wait_q <= 4'h0;
      ee_load_valid <= 1'b0;
      ee_load_high <= 32'h0000_0000;
      ee_load_low <= 32'h0000_0000;
    end
    else
    begin
      ee_load_valid <= 1'b0;
      // Lines toggle outside the pulse, never hold a stale word
      ee_load_high <= ~ee_load_high;
      ee_load_low <= ~ee_load_low;
      if (go)
      begin
        busy_q <= 1'b1;
        wait_q <= word_low[3:0];
      end
      else if (busy_q && wait_q == 4'h0)
      begin
        busy_q <= 1'b0;
        ee_load_valid <= 1'b1;
        ee_load_high <= word_high;
        ee_load_low <= word_low;
      end
      else if (busy_q)
        wait_q <= wait_q - 4'h1;
    end
  end
endmodule // bir_ee_model

/* sim/tb.sv */
// Testbench for the bus information registers
`timescale 1ns/1ps
module tb;
  import bir_pkg::*;
  logic ref_clk, rst_b, ce, psel, penable, pwrite, pready, pslverr, sw_reset, perst_b, global_reset_pin_b, por_b, e;
  logic bus_reset, rom_changed, eeprom_present, ee_load_valid, fw_load_valid, rx_blk_wr_valid, ack_type_error;
  logic id_locked, ee_go;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, ee_load_high, ee_load_low, fw_load_high, fw_load_low, ee_hi, ee_lo, opts, r, h, l;
  logic [3:0] pstrb;
  logic [15:0] rx_blk_wr_len;
  int mismatches, cmp_count;
  bir_regs bir_regs_inst (.ref_clk, .rst_b, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
    .pslverr, .sw_reset, .perst_b, .global_reset_pin_b, .por_b, .bus_reset, .rom_changed, .eeprom_present,
    .ee_load_valid, .ee_load_high, .ee_load_low, .fw_load_valid, .fw_load_high, .fw_load_low, .rx_blk_wr_valid,
    .rx_blk_wr_len, .ack_type_error, .id_locked);
  bir_ee_model bir_ee_model_inst (.ref_clk, .rst_b, .go(ee_go), .word_high(ee_hi), .word_low(ee_lo), .ee_load_valid,
    .ee_load_high, .ee_load_low);
  initial
  begin
    ref_clk = 0;
    forever #4 ref_clk = ~ref_clk;
  end
  task tally_and_finish;
    $display("mismatches %0d compares %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge ref_clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge ref_clk);
    penable <= 1;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    if (n >= 50)
    begin
      mismatches++;
      $display("BAD %0t apb timeout", $time);
      tally_and_finish();
    end
  endtask
  // Byte lanes: 3 capability, 2 accuracy, 1 request size, 0 generation
  function automatic logic [31:0] nxt(logic [31:0] o, logic [31:0] d, logic [3:0] s);
    if (s[3]) o[28:27] = d[28:27];
    if (s[2]) o[23:16] = d[23:16];
    if (s[1] && d[15:12] >= 4'h8) o[15:12] = d[15:12];
    if (s[0]) o[7:6] = d[7:6];
    return o;
  endfunction
  task id_rd(input logic [31:0] a, input logic [31:0] b);
    apb(0, BIR_OFF_ID_HIGH, 0, 4'hF);
    chk(r, a);
    apb(0, BIR_OFF_ID_LOW, 0, 4'hF);
    chk(r, b);
  endtask
  task ld(input logic ee, input logic [31:0] a, input logic [31:0] b);
    @(posedge ref_clk);
    ee_go <= ee;
    fw_load_valid <= !ee;
    {ee_hi, ee_lo, fw_load_high, fw_load_low} <= {a, b, a, b};
    @(posedge ref_clk);
    ee_go <= 0;
    fw_load_valid <= 0;
  endtask
  task blk(input logic [15:0] len, input logic x);
    @(posedge ref_clk);
    rx_blk_wr_valid <= 1;
    rx_blk_wr_len <= len;
    @(posedge ref_clk);
    rx_blk_wr_valid <= 0;
    #1;
    chk({31'h0, ack_type_error}, {31'h0, x});
  endtask
  task rd_opts;
    apb(0, BIR_OFF_OPTS, 0, 4'hF);
    chk(r, opts);
  endtask
  initial
  begin
    rst_b = 0;
    ce = 1;
    {perst_b, global_reset_pin_b, por_b} = 3'h7;
    {psel, penable, pwrite, sw_reset, bus_reset, rom_changed, eeprom_present, fw_load_valid, rx_blk_wr_valid} = 0;
    {paddr, pwdata, pstrb, rx_blk_wr_len, fw_load_high, fw_load_low, ee_hi, ee_lo, ee_go} = 0;
    mismatches = 0;
    cmp_count = 0;
    void'($urandom(32'h3083));
    repeat (12) @(posedge ref_clk);
    rst_b <= 1;
    opts = 32'h0000_B003;
    rd_opts();
    id_rd(0, 0);
    for (int i = 0; i < 14; i++)
    begin
      h = (i == 0) ? 32'h0000_7000 : (i == 1) ? 32'hFFFF_FFFF : $urandom;
      l = (i < 2) ? 32'hF : $urandom;
      apb(1, BIR_OFF_OPTS, h, l[3:0]);
      opts = nxt(opts, h, l[3:0]);
      rd_opts();
    end
    @(posedge ref_clk);
    sw_reset <= 1;
    @(posedge ref_clk);
    sw_reset <= 0;
    opts = {16'h0, opts[15:12], 12'h003};
    rd_opts();
    // A low clock enable must swallow a software reset
    @(posedge ref_clk);
    ce <= 0;
    sw_reset <= 1;
    @(posedge ref_clk);
    ce <= 1;
    sw_reset <= 0;
    rd_opts();
    // Pass 4 has the change in the bus reset cycle, pass 5 none, so a leftover pending flag shows
    for (int i = 0; i < 6; i++)
    begin
      @(posedge ref_clk);
      rom_changed <= (i < 4 && i != 2);
      @(posedge ref_clk);
      rom_changed <= (i == 4);
      bus_reset <= 1;
      @(posedge ref_clk);
      rom_changed <= 0;
      bus_reset <= 0;
      if (i != 2 && i != 5) opts[7:6] = opts[7:6] + 2'h1;
      rd_opts();
    end
    for (int m = 8; m < 15; m++)
    begin
      apb(1, BIR_OFF_OPTS, {16'h0, 4'(m), 12'h0}, 4'h2);
      blk(16'(1 << (m + 1)), 0);
      blk(16'((1 << (m + 1)) + 1), 1);
    end
    apb(1, 12'h100, $urandom, 4'hF);
    chk({31'h0, e}, 1);
    apb(0, 12'h100, 0, 4'hF);
    chk(r, 0);
    @(posedge ref_clk);
    eeprom_present <= 1;
    apb(1, BIR_OFF_ID_HIGH, 32'hFFFF_FFFF, 4'hF);
    ld(0, $urandom, $urandom);
    id_rd(0, 0);
    h = $urandom;
    l = $urandom;
    ld(1, h, l);
    for (int n = 0; n < 40 && id_locked !== 1'b1; n++) @(posedge ref_clk);
    if (id_locked !== 1'b1)
    begin
      mismatches++;
      $display("BAD %0t identifier load timeout", $time);
      tally_and_finish();
    end
    id_rd(h, l);
    apb(0, BIR_OFF_ID_STAT, 0, 4'hF);
    chk(r, 32'h0000_0003);
    ld(1, ~h, ~l);
    repeat (20) @(posedge ref_clk);
    apb(1, BIR_OFF_ID_LOW, 32'h0000_0000, 4'hF);
    id_rd(h, l);
    for (int k = 0; k < 3; k++)
    begin
      @(posedge ref_clk);
      {perst_b, global_reset_pin_b, por_b} <= ~(3'h4 >> k);
      @(posedge ref_clk);
      {perst_b, global_reset_pin_b, por_b} <= 3'h7;
      eeprom_present <= 0;
      id_rd(0, 0);
      chk({31'h0, id_locked}, 0);
      h = $urandom;
      l = $urandom;
      ld(0, h, l);
      id_rd(h, l);
    end
    @(posedge ref_clk);
    rst_b <= 0;
    repeat (2) @(posedge ref_clk);
    rst_b <= 1;
    opts = 32'h0000_B003;
    rd_opts();
    id_rd(0, 0);
    tally_and_finish();
  end
endmodule // tb
